// ### verilog/profile_position_mode_select.sv
/*
 profile-position mode decoder and move goal calculator.
 assumes an object-dictionary write/read port from the fieldbus slave
 logic on the same clock, an actual position from the encoder logic on
 the same clock, and a motion generator that pulses moveDone.
*/
// Notes on behaviour
// RULE1: mode comes from command word bits plus modulo target mode object
// RULE2: without modulo, bit6 picks absolute/incremental, bit12 picks base
// RULE3: bit13 selects the press variant of whatever mode is decoded
// RULE4: bit14 selects modulo mode, ignores bits 12 and 6
// RULE5: modulo codes 0 absolute, 1 shortest, 2 forward, 3 reverse
// RULE6: absolute mode moves to goal measured from home
// RULE7: command-based increment adds goal to command position
// RULE8: actual-based increment adds goal to measured actual position
// RULE9: after an actual-based move command position equals the endpoint
// RULE10: modulo absolute moves to goal inside the wrap range
// RULE11: modulo shortest picks the shorter direction to the goal
// RULE12: modulo forward always travels forward
// RULE13: modulo reverse always travels in reverse
// RULE14: master enables modulo and sets range, offset, mode and goal first
// RULE15: modulo range counts tenths of a revolution
// RULE16: offset ratio counts hundredths of a percent of the range
// RULE17: master writes goal then sets bit4; device starts on that edge
// RULE18: modulo move refused for mode code above 3 or modulo disabled
`timescale 1ns/1ns
`default_nettype none
`include "ppm_consts.svh"
module profile_position_mode_select #(
    parameter logic [31:0] stepsPerRev = `STEPS_PER_REV
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic objWrite,
    input wire logic objRead,
    input wire logic [15:0] objIndex,
    input wire logic [31:0] objData,
    input wire logic [31:0] actualPos,
    input wire logic moveDone,
    output logic [31:0] readData,
    output logic moveStart,
    output logic moveRefused,
    output logic [31:0] moveGoal,
    output logic moveForward,
    output logic pressMode,
    output logic [2:0] modeCode,
    output logic [31:0] commandPos
);
    ppm_pkg::state_t st_reg;
    ppm_pkg::state_t st_next;

    function automatic ppm_pkg::mode_t decodeMode(
        input logic [15:0] cw,
        input logic [31:0] mm
    );
        ppm_pkg::mode_t m;
        m = ppm_pkg::MODE_ABS;
        if (cw[`BIT_MODULO]) begin // see RULE4
            case (mm[1:0]) // see RULE5
                2'h0: m = ppm_pkg::MODE_MOD_ABS;
                2'h1: m = ppm_pkg::MODE_MOD_NEAR;
                2'h2: m = ppm_pkg::MODE_MOD_FWD;
                default: m = ppm_pkg::MODE_MOD_REV;
            endcase
        end else if (cw[`BIT_ABS_REL]) begin // see RULE2
            m = cw[`BIT_REL_BASE] ? ppm_pkg::MODE_INC_ACT : ppm_pkg::MODE_INC_CMD;
        end
        return m;
    endfunction

    // remainder into [0, r); a zero range gives zero rather than a fault
    function automatic logic signed [31:0] wrapPos(
        input logic signed [31:0] x,
        input logic signed [31:0] r
    );
        logic signed [31:0] m;
        m = 32'sh0;
        if (r > 32'sh0) begin
            m = x % r;
            if (m < 32'sh0) begin
                m = m + r;
            end
        end
        return m;
    endfunction

    logic signed [63:0] rangeWide;
    logic signed [63:0] loWide;
    logic signed [31:0] rangeSteps;
    logic signed [31:0] lowEdge;
    logic signed [31:0] curW;
    logic signed [31:0] goalW;
    logic signed [31:0] distFwd;
    logic signed [31:0] distRev;
    logic signed [31:0] base;
    logic signed [31:0] target;
    ppm_pkg::mode_t newMode;
    logic modSel;
    logic badMod;
    logic reqEdge;

    // scale divides are by constants, but the wrap remainders divide by the computed range; range is recomputed each cycle
    always_comb begin
        rangeWide = ($signed({32'h0, st_reg.modRange})
            * $signed({32'h0, stepsPerRev})) / `RANGE_TENTHS; // see RULE15
        rangeSteps = rangeWide[31:0];
        loWide = -(($signed({{32{rangeSteps[31]}}, rangeSteps})
            * $signed({32'h0, st_reg.modOffset})) / `OFFSET_FULL); // see RULE16
        lowEdge = loWide[31:0];
        curW = wrapPos($signed(st_reg.cmdPos) - lowEdge, rangeSteps);
        goalW = wrapPos($signed(st_reg.goal) - lowEdge, rangeSteps); // see RULE10
        // both distances lie in [0, range), so picking a direction is one compare
        distFwd = wrapPos(goalW - curW, rangeSteps);
        distRev = wrapPos(curW - goalW, rangeSteps);
        newMode = decodeMode(st_reg.cmdWord, st_reg.modMode); // see RULE1
        modSel = st_reg.cmdWord[`BIT_MODULO];
        badMod = modSel && ((st_reg.modMode > `MOD_CODE_MAX)
            || (st_reg.modEnable != `MOD_ENABLE_ON)); // see RULE18
        // a held request bit never restarts a move; the master must drop it first
        reqEdge = st_reg.cmdWord[`BIT_REQUEST] && !st_reg.prevReq; // see RULE17
        base = $signed(st_reg.cmdPos);
        target = $signed(st_reg.goal); // see RULE6
        case (newMode)
            ppm_pkg::MODE_INC_CMD: begin
                target = base + $signed(st_reg.goal); // see RULE7
            end
            ppm_pkg::MODE_INC_ACT: begin
                base = $signed(actualPos);
                target = base + $signed(st_reg.goal); // see RULE8
            end
            ppm_pkg::MODE_MOD_ABS: begin
                target = base + (goalW - curW); // see RULE10
            end
            ppm_pkg::MODE_MOD_NEAR: begin
                // a tie goes forward
                target = (distFwd <= distRev) ? base + distFwd
                    : base - distRev; // see RULE11
            end
            ppm_pkg::MODE_MOD_FWD: begin
                target = base + distFwd; // see RULE12
            end
            ppm_pkg::MODE_MOD_REV: begin
                target = base - distRev; // see RULE13
            end
            default: begin
                target = $signed(st_reg.goal);
            end
        endcase
    end

    always_comb begin
        st_next = st_reg;
        st_next.start = 1'b0;
        st_next.refused = 1'b0;
        st_next.prevReq = st_reg.cmdWord[`BIT_REQUEST];
        if (objWrite) begin
            if (objIndex == `IDX_CMD_WORD) begin
                st_next.cmdWord = objData[15:0];
            end else if (objIndex == `IDX_GOAL) begin
                st_next.goal = objData;
            end else if (objIndex == `IDX_MOD_MODE) begin
                st_next.modMode = objData;
            end else if (objIndex == `IDX_MOD_ENABLE) begin
                st_next.modEnable = objData;
            end else if (objIndex == `IDX_MOD_RANGE) begin
                st_next.modRange = objData;
            end else if (objIndex == `IDX_MOD_OFFSET) begin
                st_next.modOffset = objData;
            end
        end
        if (objRead) begin
            if (objIndex == `IDX_CMD_WORD) begin
                st_next.readData = {16'h0000, st_reg.cmdWord};
            end else if (objIndex == `IDX_GOAL) begin
                st_next.readData = st_reg.goal;
            end else if (objIndex == `IDX_MOD_MODE) begin
                st_next.readData = st_reg.modMode;
            end else if (objIndex == `IDX_MOD_ENABLE) begin
                st_next.readData = st_reg.modEnable;
            end else if (objIndex == `IDX_MOD_RANGE) begin
                st_next.readData = st_reg.modRange;
            end else if (objIndex == `IDX_MOD_OFFSET) begin
                st_next.readData = st_reg.modOffset;
            end else begin
                st_next.readData = 32'h00000000;
            end
        end
        // a finished move leaves the command position at the endpoint
        if (moveDone) begin
            st_next.cmdPos = st_reg.endpoint; // see RULE9
        end
        if (reqEdge) begin
            if (badMod) begin
                st_next.refused = 1'b1; // see RULE18
            end else begin
                st_next.start = 1'b1; // see RULE17
                st_next.mode = newMode;
                st_next.endpoint = target;
                st_next.press = st_reg.cmdWord[`BIT_PRESS]; // see RULE3
                st_next.forward = (target >= base);
            end
        end
    end

    // one reset value for all state keeps every output and object at zero
    always_ff @(posedge clock) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign readData = st_reg.readData;
    assign moveStart = st_reg.start;
    assign moveRefused = st_reg.refused;
    assign moveGoal = st_reg.endpoint;
    assign moveForward = st_reg.forward;
    assign pressMode = st_reg.press;
    assign modeCode = st_reg.mode;
    assign commandPos = st_reg.cmdPos;

    AST_START_ON_EDGE: assert property (@(posedge clock) disable iff (rst) // see RULE17
        (reqEdge && !badMod) |=> (moveStart && !moveRefused))
        else $error("request edge did not start a move");
    AST_REFUSE_BAD_MOD: assert property (@(posedge clock) disable iff (rst) // see RULE18
        (reqEdge && badMod) |=> (moveRefused && !moveStart))
        else $error("bad modulo setup not refused");
    AST_NO_START_WITHOUT_EDGE: assert property (@(posedge clock) disable iff (rst) // see RULE17
        !reqEdge |=> !moveStart)
        else $error("move started without request edge");
    AST_MODULO_IGNORES_BITS: assert property (@(posedge clock) disable iff (rst) // see RULE4
        (reqEdge && !badMod && modSel) |=> (modeCode >= 3'(ppm_pkg::MODE_MOD_ABS)))
        else $error("modulo select gave a linear mode");
    AST_INC_CMD_SUM: assert property (@(posedge clock) disable iff (rst) // see RULE7
        (reqEdge && newMode == ppm_pkg::MODE_INC_CMD)
        |=> (moveGoal == $past(st_reg.cmdPos) + $past(st_reg.goal)))
        else $error("command-based endpoint wrong");
    AST_INC_ACT_SUM: assert property (@(posedge clock) disable iff (rst) // see RULE8
        (reqEdge && newMode == ppm_pkg::MODE_INC_ACT)
        |=> (moveGoal == $past(actualPos) + $past(st_reg.goal)))
        else $error("actual-based endpoint wrong");
    AST_ABS_GOAL: assert property (@(posedge clock) disable iff (rst) // see RULE6
        (reqEdge && newMode == ppm_pkg::MODE_ABS) |=> (moveGoal == $past(st_reg.goal)))
        else $error("absolute endpoint wrong");
    AST_PRESS_FOLLOWS_BIT: assert property (@(posedge clock) disable iff (rst) // see RULE3
        (reqEdge && !badMod) |=> (pressMode == $past(st_reg.cmdWord[`BIT_PRESS])))
        else $error("press flag wrong");
    AST_DONE_SETS_POS: assert property (@(posedge clock) disable iff (rst) // see RULE9
        moveDone |=> (commandPos == $past(st_reg.endpoint)))
        else $error("command position not at endpoint after done");
    AST_FWD_DIR: assert property (@(posedge clock) disable iff (rst) // see RULE12
        (reqEdge && !badMod && newMode == ppm_pkg::MODE_MOD_FWD) |=> moveForward)
        else $error("forward modulo move not forward");
    AST_REV_DIR: assert property (@(posedge clock) disable iff (rst) // see RULE13
        (reqEdge && !badMod && newMode == ppm_pkg::MODE_MOD_REV)
        |=> (!moveForward || moveGoal == $past(st_reg.cmdPos)))
        else $error("reverse modulo move not reverse");
    AST_NEAR_SHORT: assert property (@(posedge clock) disable iff (rst) // see RULE11
        (reqEdge && !badMod && newMode == ppm_pkg::MODE_MOD_NEAR && distFwd < distRev)
        |=> moveForward)
        else $error("shortest move took the long way");

    // move outputs stand between starts; a refusal leaves them alone
    AST_START_SINGLE: assert property (@(posedge clock) disable iff (rst) // see RULE17
        moveStart |=> !moveStart)
        else $error("move start lasted more than one cycle");
    AST_OUTPUTS_HOLD: assert property (@(posedge clock) disable iff (rst) // see RULE17
        !moveStart |-> ($stable(moveGoal) && $stable(modeCode)
        && $stable(pressMode) && $stable(moveForward)))
        else $error("move outputs changed without a start");
    AST_REFUSE_NEEDS_MODULO: assert property (@(posedge clock) disable iff (rst) // see RULE18
        moveRefused |-> $past(modSel))
        else $error("linear request was refused");
    AST_LINEAR_MODE_CODE: assert property (@(posedge clock) disable iff (rst) // see RULE2
        (reqEdge && !modSel) |=> (modeCode <= 3'(ppm_pkg::MODE_INC_ACT)))
        else $error("linear request gave a modulo mode");
    AST_CMDPOS_HOLDS: assert property (@(posedge clock) disable iff (rst) // see RULE9
        !moveDone |=> $stable(commandPos))
        else $error("command position moved without done");
    AST_DISABLED_REFUSED: assert property (@(posedge clock) disable iff (rst) // see RULE18
        (reqEdge && modSel && (st_reg.modEnable != `MOD_ENABLE_ON))
        |=> (moveRefused && !moveStart))
        else $error("modulo move started while disabled");
    AST_BAD_CODE_REFUSED: assert property (@(posedge clock) disable iff (rst) // see RULE18
        (reqEdge && modSel && (st_reg.modMode > `MOD_CODE_MAX))
        |=> (moveRefused && !moveStart))
        else $error("modulo move started with a bad mode code");
    AST_NEAR_NOT_LONG: assert property (@(posedge clock) disable iff (rst) // see RULE11
        (reqEdge && !badMod && newMode == ppm_pkg::MODE_MOD_NEAR && distRev < distFwd)
        |=> (!moveForward || moveGoal == $past(st_reg.cmdPos)))
        else $error("shortest move went forward the long way");

    COV_INC_ACT: cover property (@(posedge clock) disable iff (rst)
        reqEdge && newMode == ppm_pkg::MODE_INC_ACT ##1 moveStart);
    COV_MOD_NEAR: cover property (@(posedge clock) disable iff (rst)
        reqEdge && newMode == ppm_pkg::MODE_MOD_NEAR && !badMod ##1 moveStart);
    COV_REFUSED: cover property (@(posedge clock) disable iff (rst) moveRefused);
    COV_PRESS_START: cover property (@(posedge clock) disable iff (rst)
        moveStart && pressMode);
    COV_MOD_REV: cover property (@(posedge clock) disable iff (rst)
        moveStart && modeCode == 3'(ppm_pkg::MODE_MOD_REV));
endmodule
`default_nettype wire

// ### verilog/ppm_consts.svh
/*
 holds object indices, bit positions, scale factors and reset values
 of the profile-position mode selector; assumes 16-bit object indices
*/
`ifndef PPM_CONSTS_SVH
`define PPM_CONSTS_SVH
`define IDX_MOD_MODE 16'h414f
`define IDX_MOD_ENABLE 16'h41c7
`define IDX_MOD_RANGE 16'h41c9
`define IDX_MOD_OFFSET 16'h41cb
`define IDX_CMD_WORD 16'h6040
`define IDX_GOAL 16'h607a
`define BIT_REQUEST 4
`define BIT_ABS_REL 6
`define BIT_REL_BASE 12
`define BIT_PRESS 13
`define BIT_MODULO 14
`define MOD_ENABLE_ON 32'h00000001
`define MOD_CODE_MAX 32'h00000003
`define RANGE_TENTHS 64'sh000000000000000a
`define OFFSET_FULL 64'sh0000000000002710
`define STEPS_PER_REV 32'h00002710
`define RST_WORD32 32'h00000000
`define RST_WORD16 16'h0000
`endif

// ### verilog/ppm_pkg.sv
/*
 holds the types of the profile-position mode selector;
 assumes the constants header is compiled with it
*/
`default_nettype none
package ppm_pkg;
    typedef enum logic [2:0] {
        MODE_ABS,
        MODE_INC_CMD,
        MODE_INC_ACT,
        MODE_MOD_ABS,
        MODE_MOD_NEAR,
        MODE_MOD_FWD,
        MODE_MOD_REV
    } mode_t;
    typedef struct packed {
        logic [15:0] cmdWord;
        logic [31:0] modMode;
        logic [31:0] modEnable;
        logic [31:0] modRange;
        logic [31:0] modOffset;
        logic [31:0] goal;
        logic [31:0] cmdPos;
        logic [31:0] endpoint;
        logic [31:0] readData;
        mode_t mode;
        logic prevReq;
        logic start;
        logic refused;
        logic press;
        logic forward;
    } state_t;
endpackage
`default_nettype wire

// ### verif/fieldbus_master_model.sv
/*
 fieldbus master and motion generator stand-in for the mode selector;
 assumes the selector samples on the rising edge, so all lines move on the falling edge
*/
`timescale 1ns/1ns
`default_nettype none
module fieldbus_master_model (
    input wire logic clock,
    input wire logic [31:0] readData,
    output logic objWrite,
    output logic objRead,
    output logic [15:0] objIndex,
    output logic [31:0] objData,
    output logic [31:0] actualPos,
    output logic moveDone
);
    initial begin
        objWrite = 1'b0;
        objRead = 1'b0;
        objIndex = 16'h0000;
        objData = 32'h00000000;
        actualPos = 32'h00000000;
        moveDone = 1'b0;
    end

    // goal and modulo objects are written before the request bit
    task automatic writeObj(input logic [15:0] idx, input logic [31:0] val);
        @(negedge clock);
        objWrite = 1'b1;
        objIndex = idx;
        objData = val;
        @(negedge clock);
        objWrite = 1'b0;
        // idle lines carry inverted junk so a stale value cannot pass for a write
        objIndex = ~idx;
        objData = ~val;
    endtask

    task automatic readObj(input logic [15:0] idx, output logic [31:0] val);
        @(negedge clock);
        objRead = 1'b1;
        objIndex = idx;
        @(negedge clock);
        objRead = 1'b0;
        objIndex = ~idx;
        val = readData;
    endtask

    task automatic pulseDone();
        @(negedge clock);
        moveDone = 1'b1;
        @(negedge clock);
        moveDone = 1'b0;
    endtask

    task automatic setActual(input logic [31:0] pos);
        @(negedge clock);
        actualPos = pos;
    endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
/*
 self-checking bench for the profile-position mode selector;
 assumes the master model above and the default of 10000 steps per revolution
*/
`timescale 1ns/1ns
`default_nettype none
`include "ppm_consts.svh"
module tb_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic objWrite, objRead, moveDone, moveStart, moveRefused, moveForward, pressMode;
    logic [15:0] objIndex;
    logic [31:0] objData, actualPos, readData, moveGoal, commandPos, rd;
    logic [2:0] modeCode;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    // base -100 wrapped in [-5000,5000), goal -4000: endpoints per modulo code
    logic [31:0] modGoal [4] = '{32'h00001770, 32'h00001770, 32'h00003e80, 32'h00001770};
    logic modFwd [4] = '{1'b0, 1'b0, 1'b1, 1'b0};

    always #50 clock = ~clock;

    fieldbus_master_model master (.clock(clock), .readData(readData), .objWrite(objWrite),
        .objRead(objRead), .objIndex(objIndex), .objData(objData), .actualPos(actualPos),
        .moveDone(moveDone));

    profile_position_mode_select dut (.clock(clock), .rst(rst), .objWrite(objWrite),
        .objRead(objRead), .objIndex(objIndex), .objData(objData), .actualPos(actualPos),
        .moveDone(moveDone), .readData(readData), .moveStart(moveStart),
        .moveRefused(moveRefused), .moveGoal(moveGoal), .moveForward(moveForward),
        .pressMode(pressMode), .modeCode(modeCode), .commandPos(commandPos));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // start or refusal stands from the edge after the command word write lands
    task automatic request(input logic [15:0] cw, input logic ref_, input logic [31:0] goal,
        input logic [2:0] mode, input logic press, input logic fwd);
        master.writeObj(`IDX_CMD_WORD, {16'h0000, cw});
        check({31'h0, moveStart | moveRefused}, 32'h0);
        @(negedge clock);
        check({31'h0, moveStart}, {31'h0, ~ref_});
        check({31'h0, moveRefused}, {31'h0, ref_});
        check(moveGoal, goal);
        check({29'h0, modeCode}, {29'h0, mode});
        check({31'h0, pressMode}, {31'h0, press});
        check({31'h0, moveForward}, {31'h0, fwd});
        // the request bit must fall before the next request can be seen
        master.writeObj(`IDX_CMD_WORD, 32'h00000000);
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (20) @(negedge clock);
        rst = 1'b0;
        check(commandPos, 32'h0);
        check(moveGoal, 32'h0);
        master.readObj(16'h1234, rd);
        check(rd, 32'h0);
        $display("test reset done");

        master.writeObj(`IDX_GOAL, 32'h00000fa0);
        master.readObj(`IDX_GOAL, rd);
        check(rd, 32'h00000fa0);
        request(16'h0010, 1'b0, 32'h00000fa0, 3'h0, 1'b0, 1'b1);
        master.pulseDone();
        check(commandPos, 32'h00000fa0);
        $display("test absolute done");

        master.writeObj(`IDX_GOAL, 32'h00000bb8);
        request(16'h2050, 1'b0, 32'h00001b58, 3'h1, 1'b1, 1'b1);
        master.pulseDone();
        check(commandPos, 32'h00001b58);
        $display("test incremental command done");

        // actual lags command by 100 steps, as after a push
        master.setActual(32'h00001af4);
        request(16'h1050, 1'b0, 32'h000026ac, 3'h2, 1'b0, 1'b1);
        master.pulseDone();
        check(commandPos, 32'h000026ac);
        $display("test incremental actual done");

        master.writeObj(`IDX_MOD_ENABLE, `MOD_ENABLE_ON);
        master.writeObj(`IDX_MOD_RANGE, 32'h0000000a);
        master.writeObj(`IDX_MOD_OFFSET, 32'h00001388);
        master.writeObj(`IDX_GOAL, 32'hfffff060);
        master.readObj(`IDX_MOD_OFFSET, rd);
        check(rd, 32'h00001388);
        // bits 12 and 6 set too; the modulo decode must ignore them
        for (int i = 0; i < 4; i++) begin
            master.writeObj(`IDX_MOD_MODE, 32'(i));
            request(i[0] ? 16'h7050 : 16'h5050, 1'b0, modGoal[i], 3'(3 + i), i[0],
                modFwd[i]);
        end
        $display("test modulo modes done");

        master.writeObj(`IDX_MOD_MODE, 32'h00000004);
        request(16'h5050, 1'b1, 32'h00001770, 3'h6, 1'b1, 1'b0);
        master.writeObj(`IDX_MOD_MODE, 32'h00000000);
        master.writeObj(`IDX_MOD_ENABLE, 32'h00000000);
        request(16'h4010, 1'b1, 32'h00001770, 3'h6, 1'b1, 1'b0);
        check(commandPos, 32'h000026ac);
        $display("test refusal done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
